// >>> mpe_cmd_match.sv
`timescale 1ns/1ns
// =====================================================
// DRAM command and dispatch queue matching
module mpe_cmd_match
  import mpe_pkg::*;
(
  // Filter settings
  input wire logic [4:0] command_type_filter_in,
  input wire logic cmd_qual_in,
  input wire logic [2:0] sched_mode_filter_in,
  input wire logic sched_ign_in,
  input wire logic [3:0] disp_cond_in,
  // Events
  mpe_evt_if.sink evt,
  // Match results
  output logic dram_hit_out,
  output logic disp_hit_out
);

  // Documented command codes only
  function automatic logic known_cmd(input logic [4:0] c);
    known_cmd = (c <= CMD_CAS_WR_CLOSED) || (c == CMD_MODE_SET) || (c == CMD_REFRESH) ||
      (c == CMD_ENTER_SR) || (c == CMD_EXIT_SR) || (c == CMD_NO_OP) || (c == CMD_TRICKLE) ||
      (c == CMD_PRECHARGE) || (c == CMD_SYNC) || (c == CMD_CKE_HIGH) || (c == CMD_CKE_LOW) ||
      (c == CMD_SOFT_RESET) || (c == CMD_WR_CONFIG) || (c == CMD_RD_CONFIG) || (c == CMD_IMP_CAL);
  endfunction : known_cmd

  logic mode_ok;
  logic type_ok;

  // Mode qualifier and type match
  always_comb begin
    mode_ok = sched_ign_in || (evt.sched_mode == sched_mode_filter_in);
    type_ok = known_cmd(evt.cmd_type) && (evt.cmd_type == command_type_filter_in);
    dram_hit_out = evt.cmd_valid && mode_ok && (!cmd_qual_in || type_ok);
    disp_hit_out = $onehot(disp_cond_in) && |(disp_cond_in & evt.queue_state);
  end

endmodule : mpe_cmd_match

// >>> mpe_event_select.sv
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ns
module mpe_event_select
  import mpe_pkg::*;
#(
  parameter int NCNT = 4,
  parameter int CW = 32
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // DRAM commands and scheduler mode
  input wire logic dram_cmd_valid_in,
  input wire logic [4:0] dram_cmd_type_in,
  input wire logic [2:0] sched_mode_in,
  // Dispatch queue state
  input wire logic read_queue_full_in,
  input wire logic write_queue_full_in,
  input wire logic read_queue_empty_in,
  input wire logic write_queue_empty_in,
  // Fill/victim path events
  input wire logic link_crc_error_in,
  input wire logic ecc_error_in,
  input wire logic poisoned_transaction_in,
  input wire logic alert_frame_in,
  input wire logic fast_reset_in,
  input wire logic bcmd_valid_in,
  input wire logic bcmd_write_in,
  input wire logic rsp_valid_in,
  input wire logic [2:0] rsp_type_in,
  input wire logic northbound_debug_trigger_in,
  // Per-counter hit flags
  output logic [NCNT-1:0] event_hit_out
);

  // =====================================================
  // State
  typedef struct packed {
    logic [4:0] command_type_filter;
    logic cmd_qual;
    logic [2:0] sched_mode_filter;
    logic sched_ign;
    logic [3:0] disp_cond;
    logic [3:0][2:0] fill_victim_event;
    logic [2:0] rsp_match;
    logic [2:0] bcmd_match;
    logic [NCNT-1:0][5:0] cnt_sel;
    logic [NCNT-1:0][CW-1:0] cnt;
    logic [31:0] rdata;
    logic [NCNT-1:0] hit;
  } mpe_st_s;

  mpe_st_s st_r;
  mpe_st_s st_nxt;

  // =====================================================
  // Address decode helpers
  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    in_bank = (a[1:0] == 2'b00) && (a >= base) && (a < base + 8'(4 * NCNT));
  endfunction : in_bank

  function automatic int bank_idx(input logic [7:0] a, input logic [7:0] base);
    bank_idx = int'((a - base) >> 2);
  endfunction : bank_idx

  // =====================================================
  // Event bundle
  mpe_evt_if evt ();

  // Same-clock scheduler signals, no synchroniser needed
  assign evt.cmd_valid = dram_cmd_valid_in;
  assign evt.cmd_type = dram_cmd_type_in;
  assign evt.sched_mode = sched_mode_in;
  assign evt.queue_state = {write_queue_empty_in, read_queue_empty_in, write_queue_full_in,
    read_queue_full_in};
  assign evt.link_crc_error = link_crc_error_in;
  assign evt.ecc_error = ecc_error_in;
  assign evt.poisoned_transaction = poisoned_transaction_in;
  assign evt.alert_frame = alert_frame_in;
  assign evt.fast_reset = fast_reset_in;
  assign evt.bcmd_valid = bcmd_valid_in;
  assign evt.bcmd_write = bcmd_write_in;
  assign evt.rsp_valid = rsp_valid_in;
  assign evt.rsp_type = rsp_type_in;
  assign evt.northbound_debug_trigger = northbound_debug_trigger_in;

  // =====================================================
  // Match logic
  logic dram_hit;
  logic disp_hit;
  logic [3:0] fv_hit;

  mpe_cmd_match u_cmd (
    .command_type_filter_in(st_r.command_type_filter),
    .cmd_qual_in(st_r.cmd_qual),
    .sched_mode_filter_in(st_r.sched_mode_filter),
    .sched_ign_in(st_r.sched_ign),
    .disp_cond_in(st_r.disp_cond),
    .evt(evt.sink),
    .dram_hit_out(dram_hit),
    .disp_hit_out(disp_hit)
  );

  // Four selectors share the response and command match fields
  for (genvar g = 0; g < 4; g++) begin : g_fv
    mpe_fv_sel u_sel (
      .sel_in(st_r.fill_victim_event[g]),
      .rsp_match_in(st_r.rsp_match),
      .bcmd_match_in(st_r.bcmd_match),
      .evt(evt.sink),
      .hit_out(fv_hit[g])
    );
  end

  // Per-counter event routing
  logic [NCNT-1:0] cnt_hit;

  always_comb begin
    for (int i = 0; i < NCNT; i++) begin
      case (st_r.cnt_sel[i][4:0])
        EVT_DISPATCH: cnt_hit[i] = disp_hit;
        EVT_DRAM_CMD: cnt_hit[i] = dram_hit;
        EVT_FV_BASE: cnt_hit[i] = fv_hit[0];
        EVT_FV_BASE + 5'h01: cnt_hit[i] = fv_hit[1];
        EVT_FV_BASE + 5'h02: cnt_hit[i] = fv_hit[2];
        EVT_FV_BASE + 5'h03: cnt_hit[i] = fv_hit[3];
        default: cnt_hit[i] = 1'b0;
      endcase
      cnt_hit[i] = cnt_hit[i] && st_r.cnt_sel[i][SEL_EN_BIT];
    end
  end

  // =====================================================
  // Next state: register writes, counting, read data
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = RST_WORD;
    st_nxt.hit = cnt_hit;
    // Counters add one per qualified cycle
    for (int i = 0; i < NCNT; i++) begin
      if (cnt_hit[i]) begin
        st_nxt.cnt[i] = st_r.cnt[i] + CW'(1);
      end
    end
    if (wr_in) begin
      if (addr_in == OFF_CMD) begin
        st_nxt.command_type_filter = wdata_in[CMD_TYPE_LSB +: 5];
        st_nxt.cmd_qual = wdata_in[CMD_QUAL_BIT];
      end
      if (addr_in == OFF_SCHED) begin
        st_nxt.sched_mode_filter = wdata_in[SCHED_LSB +: 3];
        st_nxt.sched_ign = wdata_in[SCHED_IGN_BIT];
      end
      if (addr_in == OFF_DISP) begin
        st_nxt.disp_cond = wdata_in[DISP_LSB +: 4];
      end
      if (addr_in == OFF_FV) begin
        for (int k = 0; k < 4; k++) begin
          st_nxt.fill_victim_event[k] = wdata_in[FV_EV_LSB + FV_EV_STEP * k +: 3];
        end
        st_nxt.rsp_match = wdata_in[FV_RSP_LSB +: 3];
        st_nxt.bcmd_match = wdata_in[FV_BCMD_LSB +: 3];
      end
      // Software load of a counter beats a coincident count
      if (in_bank(addr_in, OFF_SEL)) begin
        st_nxt.cnt_sel[bank_idx(addr_in, OFF_SEL)] = wdata_in[5:0];
      end
      if (in_bank(addr_in, OFF_CNT)) begin
        st_nxt.cnt[bank_idx(addr_in, OFF_CNT)] = wdata_in[CW-1:0];
      end
    end
    if (rd_in) begin
      if (addr_in == OFF_CMD) begin
        st_nxt.rdata[CMD_TYPE_LSB +: 5] = st_r.command_type_filter;
        st_nxt.rdata[CMD_QUAL_BIT] = st_r.cmd_qual;
      end
      if (addr_in == OFF_SCHED) begin
        st_nxt.rdata[SCHED_LSB +: 3] = st_r.sched_mode_filter;
        st_nxt.rdata[SCHED_IGN_BIT] = st_r.sched_ign;
      end
      if (addr_in == OFF_DISP) begin
        st_nxt.rdata[DISP_LSB +: 4] = st_r.disp_cond;
      end
      if (addr_in == OFF_FV) begin
        for (int k = 0; k < 4; k++) begin
          st_nxt.rdata[FV_EV_LSB + FV_EV_STEP * k +: 3] = st_r.fill_victim_event[k];
        end
        st_nxt.rdata[FV_RSP_LSB +: 3] = st_r.rsp_match;
        st_nxt.rdata[FV_BCMD_LSB +: 3] = st_r.bcmd_match;
      end
      if (in_bank(addr_in, OFF_SEL)) begin
        st_nxt.rdata[5:0] = st_r.cnt_sel[bank_idx(addr_in, OFF_SEL)];
      end
      if (in_bank(addr_in, OFF_CNT)) begin
        st_nxt.rdata[CW-1:0] = st_r.cnt[bank_idx(addr_in, OFF_CNT)];
      end
      // Live match status
      if (addr_in == OFF_STAT) begin
        st_nxt.rdata[7:0] = {fv_hit, 2'b00, disp_hit, dram_hit};
      end
    end
  end

  // =====================================================
  // State register, frozen while the enable is low
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign rdata_out = st_r.rdata;
  assign event_hit_out = st_r.hit;

  // =====================================================
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  AST_DISP_WRITE_QUEUE_FULL: assert property (
    (st_r.disp_cond == 4'h2) && write_queue_full_in |-> disp_hit)
    else $error("write queue full not matched");

  AST_DISP_ONEHOT: assert property (
    !$onehot(st_r.disp_cond) |-> !disp_hit)
    else $error("non one-hot dispatch field matched");

  AST_MODE_QUAL: assert property (
    st_r.cmd_qual && !st_r.sched_ign && dram_cmd_valid_in && (dram_cmd_type_in == CMD_CAS_WR_CLOSED) &&
    (st_r.command_type_filter == CMD_CAS_WR_CLOSED) |-> dram_hit == (sched_mode_in == st_r.sched_mode_filter))
    else $error("qualified command ignored scheduling mode");

  AST_MODE_ALL: assert property (
    !st_r.cmd_qual && !st_r.sched_ign && dram_cmd_valid_in |->
    dram_hit == (sched_mode_in == st_r.sched_mode_filter))
    else $error("unqualified command mode match wrong");

  AST_CMD_REFRESH: assert property (
    st_r.cmd_qual && st_r.sched_ign && (st_r.command_type_filter == CMD_REFRESH) && dram_cmd_valid_in |->
    dram_hit == (dram_cmd_type_in == CMD_REFRESH))
    else $error("refresh command match wrong");

  AST_RSP_NONE: assert property (
    (st_r.fill_victim_event[0] == RSP_NONE) && (st_r.rsp_match == RSP_NONE) |-> !fv_hit[0])
    else $error("reserved response selection counted");

  AST_NB_DEBUG: assert property (
    (st_r.fill_victim_event[1] == 3'h7) |-> fv_hit[1] == northbound_debug_trigger_in)
    else $error("debug trigger selection wrong");

  AST_BCMD_WRITE: assert property (
    (st_r.fill_victim_event[2] == 3'h5) && (st_r.bcmd_match == BCMD_WRITE) |->
    fv_hit[2] == (bcmd_valid_in && bcmd_write_in))
    else $error("command write match wrong");

  AST_CNT_INC: assert property (
    ce_in && cnt_hit[0] && !(wr_in && in_bank(addr_in, OFF_CNT)) |=>
    st_r.cnt[0] == $past(st_r.cnt[0]) + CW'(1) ##1 1'b1)
    else $error("counter did not add one");

  AST_CE_FREEZE: assert property (
    !ce_in |=> $stable(st_r.cnt) && $stable(rdata_out))
    else $error("state changed with enable low");

  // Counting, register port and dispatch checks
  AST_HIT_ONE: assert property (
    ce_in && !wr_in |=> (st_r.cnt[1] - $past(st_r.cnt[1])) <= CW'(1))
    else $error("counter stepped by more than one");

  AST_HIT_OUT: assert property (
    ce_in |=> event_hit_out == $past(cnt_hit))
    else $error("hit flags do not follow matches");

  AST_RDATA_IDLE: assert property (
    ce_in && !rd_in |=> rdata_out == 32'h0000_0000)
    else $error("read data stood beyond one cycle");

  AST_CNT_LOAD: assert property (
    ce_in && wr_in && (addr_in == OFF_CNT) |=> st_r.cnt[0] == $past(wdata_in[CW-1:0]))
    else $error("counter load lost");

  AST_SEL_OFF: assert property (
    !st_r.cnt_sel[0][SEL_EN_BIT] |-> !cnt_hit[0])
    else $error("disabled counter select matched");

  AST_DISP_READ_QUEUE_EMPTY: assert property (
    (st_r.disp_cond == 4'h4) |-> disp_hit == read_queue_empty_in)
    else $error("read queue empty not matched");

  // Fill/victim selector checks
  AST_FV_CRC: assert property (
    (st_r.fill_victim_event[3] == 3'h0) |-> fv_hit[3] == link_crc_error_in)
    else $error("link error selection wrong");

  AST_FV_FAST_RST: assert property (
    (st_r.fill_victim_event[2] == 3'h4) |-> fv_hit[2] == fast_reset_in)
    else $error("fast reset selection wrong");

  AST_RSP_MATCH: assert property (
    (st_r.fill_victim_event[3] == 3'h6) && (st_r.rsp_match != RSP_NONE) |->
    fv_hit[3] == (rsp_valid_in && (rsp_type_in == st_r.rsp_match)))
    else $error("response selection wrong");

  AST_BCMD_READ: assert property (
    (st_r.fill_victim_event[3] == 3'h5) && (st_r.bcmd_match == BCMD_READ) |->
    fv_hit[3] == (bcmd_valid_in && !bcmd_write_in))
    else $error("command read match wrong");

  // Command filter checks
  AST_CMD_PRECHARGE: assert property (
    st_r.cmd_qual && st_r.sched_ign && (st_r.command_type_filter == CMD_PRECHARGE) && dram_cmd_valid_in |->
    dram_hit == (dram_cmd_type_in == CMD_PRECHARGE))
    else $error("precharge command match wrong");

  AST_CMD_IMP_CAL: assert property (
    st_r.cmd_qual && st_r.sched_ign && (st_r.command_type_filter == CMD_IMP_CAL) && dram_cmd_valid_in |->
    dram_hit == (dram_cmd_type_in == CMD_IMP_CAL))
    else $error("calibration command match wrong");

endmodule : mpe_event_select

// >>> mpe_evt_if.sv
`timescale 1ns/1ns
// =====================================================
// Scheduler event bundle shared by the match modules
interface mpe_evt_if;
  logic cmd_valid;
  logic [4:0] cmd_type;
  logic [2:0] sched_mode;
  logic [3:0] queue_state;
  logic link_crc_error;
  logic ecc_error;
  logic poisoned_transaction;
  logic alert_frame;
  logic fast_reset;
  logic bcmd_valid;
  logic bcmd_write;
  logic rsp_valid;
  logic [2:0] rsp_type;
  logic northbound_debug_trigger;

  modport src (output cmd_valid, cmd_type, sched_mode, queue_state, link_crc_error, ecc_error,
    poisoned_transaction, alert_frame, fast_reset, bcmd_valid, bcmd_write, rsp_valid, rsp_type,
    northbound_debug_trigger);
  modport sink (input cmd_valid, cmd_type, sched_mode, queue_state, link_crc_error, ecc_error,
    poisoned_transaction, alert_frame, fast_reset, bcmd_valid, bcmd_write, rsp_valid, rsp_type,
    northbound_debug_trigger);
endinterface : mpe_evt_if

// >>> mpe_fv_sel.sv
`timescale 1ns/1ns
// =====================================================
// One fill/victim path event selector
module mpe_fv_sel
  import mpe_pkg::*;
(
  // Selector settings
  input wire logic [2:0] sel_in,
  input wire logic [2:0] rsp_match_in,
  input wire logic [2:0] bcmd_match_in,
  // Events
  mpe_evt_if.sink evt,
  // Match result
  output logic hit_out
);

  // Selector decode
  always_comb begin
    case (mpe_fv_e'(sel_in))
      FV_CRC: hit_out = evt.link_crc_error;
      FV_ECC: hit_out = evt.ecc_error;
      FV_POISON: hit_out = evt.poisoned_transaction;
      FV_ALERT: hit_out = evt.alert_frame;
      FV_FAST_RST: hit_out = evt.fast_reset;
      FV_BCMD: hit_out = evt.bcmd_valid && (((bcmd_match_in == BCMD_READ) && !evt.bcmd_write) ||
        ((bcmd_match_in == BCMD_WRITE) && evt.bcmd_write));
      FV_RSP: hit_out = evt.rsp_valid && (rsp_match_in != RSP_NONE) &&
        (evt.rsp_type == rsp_match_in);
      FV_NB_DEBUG: hit_out = evt.northbound_debug_trigger;
      default: hit_out = 1'b0;
    endcase
  end

endmodule : mpe_fv_sel

// >>> mpe_pkg.sv
// =====================================================
// Shared constants for the memory scheduler event select
package mpe_pkg;

  // =====================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_SCHED = 8'h04;
  localparam logic [7:0] OFF_DISP = 8'h08;
  localparam logic [7:0] OFF_FV = 8'h0c;
  localparam logic [7:0] OFF_SEL = 8'h10;
  localparam logic [7:0] OFF_CNT = 8'h20;
  localparam logic [7:0] OFF_STAT = 8'h30;

  // =====================================================
  // Field positions
  localparam int CMD_QUAL_BIT = 0;
  localparam int CMD_TYPE_LSB = 8;
  localparam int SCHED_LSB = 7;
  localparam int SCHED_IGN_BIT = 10;
  localparam int DISP_LSB = 7;
  localparam int FV_BCMD_LSB = 5;
  localparam int FV_RSP_LSB = 8;
  localparam int FV_EV_LSB = 11;
  localparam int FV_EV_STEP = 3;
  localparam int SEL_EN_BIT = 5;

  // =====================================================
  // Values after reset
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [5:0] RST_SEL = 6'h00;

  // =====================================================
  // Event codes for the counter selects
  localparam logic [4:0] EVT_DISPATCH = 5'h00;
  localparam logic [4:0] EVT_DRAM_CMD = 5'h0a;
  localparam logic [4:0] EVT_FV_BASE = 5'h0d;

  // =====================================================
  // DRAM command type codes
  localparam logic [4:0] CMD_MODE_SET = 5'h07;
  localparam logic [4:0] CMD_REFRESH = 5'h09;
  localparam logic [4:0] CMD_ENTER_SR = 5'h0a;
  localparam logic [4:0] CMD_EXIT_SR = 5'h0b;
  localparam logic [4:0] CMD_NO_OP = 5'h0c;
  localparam logic [4:0] CMD_TRICKLE = 5'h10;
  localparam logic [4:0] CMD_PRECHARGE = 5'h11;
  localparam logic [4:0] CMD_SYNC = 5'h12;
  localparam logic [4:0] CMD_CKE_HIGH = 5'h14;
  localparam logic [4:0] CMD_CKE_LOW = 5'h15;
  localparam logic [4:0] CMD_SOFT_RESET = 5'h17;
  localparam logic [4:0] CMD_WR_CONFIG = 5'h1c;
  localparam logic [4:0] CMD_RD_CONFIG = 5'h1d;
  localparam logic [4:0] CMD_IMP_CAL = 5'h1e;
  localparam logic [4:0] CMD_CAS_WR_CLOSED = 5'h06;

  // =====================================================
  // Fill/victim selector values
  typedef enum logic [2:0] {
    FV_CRC = 3'h0, FV_ECC = 3'h1, FV_POISON = 3'h2, FV_ALERT = 3'h3,
    FV_FAST_RST = 3'h4, FV_BCMD = 3'h5, FV_RSP = 3'h6, FV_NB_DEBUG = 3'h7
  } mpe_fv_e;
  localparam logic [2:0] RSP_NONE = 3'h6;
  localparam logic [2:0] BCMD_READ = 3'h0;
  localparam logic [2:0] BCMD_WRITE = 3'h1;

  // Scheduling modes
  typedef enum logic [2:0] {
    tradeoff_schedule = 3'h0, read_priority_schedule = 3'h1,
    write_priority_schedule = 3'h2, adaptive_schedule = 3'h3
  } mpe_sched_e;

endpackage : mpe_pkg

// >>> testbench.sv
`timescale 1ns/1ns
// =====================================================
// Self-checking bench for the event select block
module testbench;
  import mpe_pkg::*;

  // =====================================================
  // Design inputs, all quiet at time zero
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic dram_cmd_valid_in = 1'b0;
  logic [4:0] dram_cmd_type_in = 5'h00;
  logic [2:0] sched_mode_in = 3'h0;
  logic read_queue_full_in = 1'b0;
  logic write_queue_full_in = 1'b0;
  logic read_queue_empty_in = 1'b0;
  logic write_queue_empty_in = 1'b0;
  logic link_crc_error_in = 1'b0;
  logic ecc_error_in = 1'b0;
  logic poisoned_transaction_in = 1'b0;
  logic alert_frame_in = 1'b0;
  logic fast_reset_in = 1'b0;
  logic bcmd_valid_in = 1'b0;
  logic bcmd_write_in = 1'b0;
  logic rsp_valid_in = 1'b0;
  logic [2:0] rsp_type_in = 3'h0;
  logic northbound_debug_trigger_in = 1'b0;
  logic [31:0] rdata_out;
  logic [3:0] event_hit_out;

  // =====================================================
  // Bench state and the settings mirrored for prediction
  integer seed = 85076;
  int error_cnt = 0;
  int total_checks = 0;
  logic [31:0] cmd_cfg, sched_cfg, disp_cfg, fv_cfg, rd_val;
  logic [5:0] sel_cfg [4];
  logic [31:0] exp_cnt [4];
  logic [3:0] h1, h2;
  logic [4:0] codes [7] = '{5'h00, 5'h0a, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h01};
  logic [4:0] types [14] = '{5'h07, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h10, 5'h11, 5'h12, 5'h14, 5'h15, 5'h17, 5'h1c,
    5'h1d, 5'h1e};
  logic [7:0] rst_addr [7] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h2c, 8'h3c, 8'h30};

  mpe_event_select #(.NCNT(4), .CW(32)) uut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .dram_cmd_valid_in(dram_cmd_valid_in), .dram_cmd_type_in(dram_cmd_type_in), .sched_mode_in(sched_mode_in),
    .read_queue_full_in(read_queue_full_in), .write_queue_full_in(write_queue_full_in),
    .read_queue_empty_in(read_queue_empty_in), .write_queue_empty_in(write_queue_empty_in),
    .link_crc_error_in(link_crc_error_in), .ecc_error_in(ecc_error_in),
    .poisoned_transaction_in(poisoned_transaction_in), .alert_frame_in(alert_frame_in),
    .fast_reset_in(fast_reset_in), .bcmd_valid_in(bcmd_valid_in), .bcmd_write_in(bcmd_write_in),
    .rsp_valid_in(rsp_valid_in), .rsp_type_in(rsp_type_in),
    .northbound_debug_trigger_in(northbound_debug_trigger_in), .event_hit_out(event_hit_out));

  // =====================================================
  // Clock generator
  initial begin
    forever #5 clk_in = ~clk_in;
  end

  // Compare and count
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : rd

  // Predicted match of counter i for one packed event sample
  function automatic logic hit(input int i, input logic [23:0] e);
    logic [4:0] code;
    logic [2:0] s;
    code = sel_cfg[i][4:0];
    hit = 1'b0;
    if (!sel_cfg[i][5]) return 1'b0;
    if (code == 5'h00) begin
      hit = (disp_cfg[10:7] == 4'h1 && e[8]) || (disp_cfg[10:7] == 4'h2 && e[9]) ||
        (disp_cfg[10:7] == 4'h4 && e[10]) || (disp_cfg[10:7] == 4'h8 && e[11]);
    end else if (code == 5'h0a) begin
      hit = e[0] && (sched_cfg[10] || sched_cfg[9:7] == {1'b0, e[7:6]}) && (!cmd_cfg[0] || cmd_cfg[12:8] == e[5:1]);
    end else if (code >= 5'h0d && code <= 5'h10) begin
      s = fv_cfg[11 + 3 * int'(code - 5'h0d) +: 3];
      if (s < 3'h5) hit = e[12 + s];
      else if (s == 3'h5) hit = e[17] && ((fv_cfg[7:5] == 3'h0 && !e[18]) || (fv_cfg[7:5] == 3'h1 && e[18]));
      else if (s == 3'h6) hit = e[19] && fv_cfg[10:8] != 3'h6 && e[22:20] == fv_cfg[10:8];
      else hit = e[23];
    end
  endfunction : hit

  // Put one packed event sample and the enable on the ports
  task automatic drive(input logic [23:0] e, input logic c);
    ce_in <= c;
    dram_cmd_valid_in <= e[0];
    dram_cmd_type_in <= e[5:1];
    sched_mode_in <= {1'b0, e[7:6]};
    {write_queue_empty_in, read_queue_empty_in, write_queue_full_in, read_queue_full_in} <= e[11:8];
    {fast_reset_in, alert_frame_in, poisoned_transaction_in, ecc_error_in, link_crc_error_in} <= e[16:12];
    bcmd_valid_in <= e[17];
    bcmd_write_in <= e[18];
    rsp_valid_in <= e[19];
    rsp_type_in <= e[22:20];
    northbound_debug_trigger_in <= e[23];
  endtask : drive

  // Random event traffic with hit flags checked two edges later
  task automatic run(input int n);
    logic [23:0] e;
    logic c;
    logic [3:0] h;
    h1 = 4'h0;
    h2 = 4'h0;
    repeat (n) begin
      @(posedge clk_in);
      chk("event_hit_out", {28'h0, h2}, {28'h0, event_hit_out});
      e = 24'($random(seed));
      if (e[2]) e[5:1] = cmd_cfg[12:8];
      c = ($random(seed) & 7) != 0;
      for (int i = 0; i < 4; i++) begin
        h[i] = hit(i, e);
        if (c) exp_cnt[i] = exp_cnt[i] + 32'(h[i]);
      end
      h2 = h1;
      h1 = c ? h : h1;
      drive(e, c);
    end
    @(posedge clk_in);
    chk("event_hit_out", {28'h0, h2}, {28'h0, event_hit_out});
    drive(24'h0, 1'b1);
  endtask : run

  // Program all settings, clear counters, run traffic, read counters back
  task automatic round(input logic [31:0] c, input logic [31:0] s, input logic [31:0] d, input logic [31:0] f,
    input int r);
    cmd_cfg = c;
    sched_cfg = s;
    disp_cfg = d;
    fv_cfg = f;
    wr(OFF_CMD, c);
    wr(OFF_SCHED, s);
    wr(OFF_DISP, d);
    wr(OFF_FV, f);
    rd(OFF_SCHED, rd_val);
    chk("sched filter", s, rd_val);
    rd(OFF_FV, rd_val);
    chk("fill victim config", f, rd_val);
    for (int i = 0; i < 4; i++) begin
      sel_cfg[i] = {!(r % 5 == 4 && i == 0), codes[(r + i) % 7]};
      wr(OFF_SEL + 8'(4 * i), {26'h0, sel_cfg[i]});
      wr(OFF_CNT + 8'(4 * i), 32'h0);
      exp_cnt[i] = 32'h0;
    end
    run(24);
    for (int i = 0; i < 4; i++) begin
      rd(OFF_CNT + 8'(4 * i), rd_val);
      chk("counter", exp_cnt[i], rd_val);
    end
  endtask : round

  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // =====================================================
  // Watchdog
  initial begin
    #200000;
    error_cnt++;
    test_done;
  end

  // =====================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    // Reset values, unmapped and unaligned places read zero
    foreach (rst_addr[k]) begin
      rd(rst_addr[k], rd_val);
      chk("reset read", 32'h0, rd_val);
    end
    rd(8'h02, rd_val);
    chk("unaligned read", 32'h0, rd_val);
    @(posedge clk_in);
    #1 chk("rdata after read", 32'h0, rdata_out);
    // Counter load by software
    wr(OFF_CNT + 8'h0c, 32'h89ab_cdef);
    rd(OFF_CNT + 8'h0c, rd_val);
    chk("counter load", 32'h89ab_cdef, rd_val);
    // Every named command type above CMD_CAS_WR_CLOSED with qualify set
    for (int k = 0; k < 14; k++) begin
      round({19'h0, types[k], 7'h0, 1'b1}, 32'h0000_0400, 32'(4'h1 << (k % 4)) << 7,
        32'($random(seed)) & 32'h007f_ffe0, k);
    end
    // Mode qualification with and without the type filter
    for (int j = 0; j < 8; j++) begin
      round({19'h0, CMD_CAS_WR_CLOSED, 7'h0, j[2]}, 32'(j[1:0]) << 7, 32'($random(seed) & 15) << 7,
        32'($random(seed)) & 32'h007f_ffe0, j + 1);
    end
    // Every selector value in every slot, every response and command match
    for (int k = 0; k < 16; k++) begin
      round({19'h0, types[k % 14], 7'h0, k[0]}, 32'(k[2:0]) << 7, 32'(4'h1 << (k % 4)) << 7,
        {9'h0, 3'(k + 3), 3'(k + 2), 3'(k + 1), 3'(k), 3'(k), 3'(k / 3), 5'h0}, k);
    end
    test_done;
  end

endmodule : testbench
